// ### pld_led_board.sv
// Board LED model: turns pin levels into lit states.
// Assumes the bench hands it each port's polarity bit.
`timescale 1ns/10ps
module pld_led_board
(
   input wire logic [1:0] pin_a,
   input wire logic [1:0] pol_a,
   output logic [1:0]     lit_a
);
   // Low pin lights the LED unless active high is chosen
   assign lit_a = ~(pin_a ^ pol_a);
endmodule : pld_led_board

// ### pld_led_driver.sv
// LED status driver for a group of PHY ports: two direct LED pins per
// port, mode select, combine, blink or pulse-stretch, pulsing, polarity.
// Assumes port status is synchronous to core_clk and an AXI4-Lite master.
//
// Operation
// - Each port drives two direct LED pins, a and b.
// - Per-pin polarity bits 11:10; reset value makes every pin active low.
// - Mode 0: off without link, on with link, blink on activity.
// - Modes 1-3: as mode 0 for gigabit, 100 Mb/s, 10 Mb/s copper.
// - Modes 4-7: speed groups 100/1000, 10/1000, 10/100, fiber 100/1000.
// - Mode 8: on full duplex, blink on half-duplex collisions.
// - Modes 9-11: collision, activity or tx only, fiber activity or rx only.
// - Mode 12: on while autonegotiation fault present.
// - Mode 13 selects serial stream hook, port 0 only.
// - Modes 14/15 force off/on and suppress post-reset blink.
// - Extended enable bit per pin makes effective mode 16 plus field.
// - Modes 16-19: fiber gigabit/100 link, fiber gigabit/100 activity.
// - Mode 20 forces off; mode 21 forces on without pulsing.
// - Mode 22 puts fast link failure on pin a only.
// - Combine on adds activity or collision blinking to primary status, else primary only.
// - Per-pin choice of 50% blink or minimum-time pulse-stretch.
// - Blink rate 2.5, 5, 10 or 20 Hz, equal high and low.
// - Stretch length 50, 100, 200 or 400 ms.
// - Port 0 rate setting governs all pins; other ports ignored.
// - Pulsing drives asserted LEDs at 5 kHz, 20% duty.
// - All LEDs blink one second after reset unless disabled.
// - Fiber disable masks fiber link and activity, except mode 10 tx only and mode 22.
// - Fast link failure is inverse link-up except gigabit copper.
`timescale 1ns/10ps
`include "pld_params.svh"

module pld_led_driver
   import pld_pkg::*;
#(
   parameter int MS_CYCLES    = `PLD_CLK_HZ / `PLD_MS_PER_S,
   parameter int PULSE_CYCLES = `PLD_CLK_HZ / `PLD_PULSE_HZ,
   parameter int PULSE_ON     = PULSE_CYCLES * `PLD_PULSE_DUTY_PCT / 100
)
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire pld_axil_req_t       axil_req,
   output pld_axil_rsp_t            axil_rsp,
   input  wire pld_stat_t [PLD_NP-1:0] port_stat,
   input  wire logic                serial_led_in,
   output logic [PLD_NP-1:0]        led_out_a,
   output logic [PLD_NP-1:0]        led_out_b,
   output logic [PLD_NP-1:0]        fast_link_fail
);

   localparam int NL = 2 * PLD_NP;

   // Register file, one set per port
   logic [15:0] mode_reg  [PLD_NP];
   logic [15:0] behav_reg [PLD_NP];
   logic [15:0] ext_reg   [PLD_NP];
   logic [15:0] pol_reg   [PLD_NP];

   // Bus side state
   logic        aw_got_reg;
   logic [7:0]  aw_addr_reg;
   logic        w_got_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   // Timing state
   logic [17:0] ms_cnt_reg;
   logic        ms_tick;
   logic [7:0]  blink_cnt_reg;
   logic        blink_phase_reg;
   logic [15:0] pulse_cnt_reg;
   logic        pulse_on;
   logic [9:0]  rb_cnt_reg;
   logic        rb_active_reg;
   logic [7:0]  blink_half;
   logic [8:0]  stretch_len;
   logic [NL-1:0] led_on;
   logic [NL-1:0] led_pin_reg;

   // Response struct wired from flops
   assign axil_rsp.awready = ~aw_got_reg & ~bvalid_reg;
   assign axil_rsp.wready  = ~w_got_reg & ~bvalid_reg;
   assign axil_rsp.bvalid  = bvalid_reg;
   assign axil_rsp.bresp   = bresp_reg;
   assign axil_rsp.arready = ~rvalid_reg;
   assign axil_rsp.rvalid  = rvalid_reg;
   assign axil_rsp.rdata   = rdata_reg;
   assign axil_rsp.rresp   = rresp_reg;

   // Address decode: hit flag and register slot, no port index
   function automatic logic [2:0] pld_dec(logic [7:0] a);
      logic [2:0] r;
      r = 3'h0;
      if (a[7:5] == 3'h0 && a[1:0] == 2'h0)
      begin
         r = {1'b1, a[3:2]};
      end
      return r;
   endfunction : pld_dec

   // Write address and data, taken in either order
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_got_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_got_reg   <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end
      else
      begin
         if (axil_req.awvalid && axil_rsp.awready)
         begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= axil_req.awaddr;
         end
         else if (aw_got_reg && w_got_reg)
         begin
            aw_got_reg <= 1'b0;
         end
         if (axil_req.wvalid && axil_rsp.wready)
         begin
            w_got_reg  <= 1'b1;
            w_data_reg <= axil_req.wdata;
            w_strb_reg <= axil_req.wstrb;
         end
         else if (aw_got_reg && w_got_reg)
         begin
            w_got_reg <= 1'b0;
         end
      end
   end

   // Register writes and write response
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= 2'b00;
         for (int p = 0; p < PLD_NP; p++)
         begin
            mode_reg[p]  <= `PLD_RST_MODE;
            behav_reg[p] <= `PLD_RST_BEHAV;
            ext_reg[p]   <= `PLD_RST_EXT;
            pol_reg[p]   <= `PLD_RST_POL;
         end
      end
      else
      begin
         if (aw_got_reg && w_got_reg)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= 2'b10;
            for (int p = 0; p < PLD_NP; p++)
            begin
               if (aw_addr_reg[7:4] == 4'(p) && aw_addr_reg[1:0] == 2'b00)
               begin
                  bresp_reg <= 2'b00;
                  for (int b = 0; b < 2; b++)
                  begin
                     if (w_strb_reg[b])
                     begin
                        case (aw_addr_reg[3:2])
                           2'h0: mode_reg[p][8*b +: 8]  <= w_data_reg[8*b +: 8];
                           2'h1: behav_reg[p][8*b +: 8] <= w_data_reg[8*b +: 8];
                           2'h2: ext_reg[p][8*b +: 8]   <= w_data_reg[8*b +: 8];
                           default: pol_reg[p][8*b +: 8] <= w_data_reg[8*b +: 8];
                        endcase
                     end
                  end
               end
            end
            if (aw_addr_reg == `PLD_OFF_STATUS)
            begin
               bresp_reg <= 2'b00;   // Status is read-only, write ignored
            end
         end
         else if (bvalid_reg && axil_req.bready)
         begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read channel, answer one cycle after the address is taken
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= 2'b00;
      end
      else if (axil_req.arvalid && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= 2'b10;
         for (int p = 0; p < PLD_NP; p++)
         begin
            if (axil_req.araddr[7:4] == 4'(p) && axil_req.araddr[1:0] == 2'b00)
            begin
               rresp_reg <= 2'b00;
               case (axil_req.araddr[3:2])
                  2'h0: rdata_reg <= {16'h0000, mode_reg[p]};
                  2'h1: rdata_reg <= {16'h0000, behav_reg[p]};
                  2'h2: rdata_reg <= {16'h0000, ext_reg[p]};
                  default: rdata_reg <= {16'h0000, pol_reg[p]};
               endcase
            end
         end
         if (axil_req.araddr == `PLD_OFF_STATUS)
         begin
            rresp_reg <= 2'b00;
            rdata_reg <= {15'h0000, rb_active_reg, 8'h00, 4'h0, led_on};
         end
      end
      else if (rvalid_reg && axil_req.rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

   // Millisecond tick from the core clock
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ms_cnt_reg <= 18'h00000;
      end
      else if (ms_tick)
      begin
         ms_cnt_reg <= 18'h00000;
      end
      else
      begin
         ms_cnt_reg <= ms_cnt_reg + 18'h00001;
      end
   end
   assign ms_tick = (ms_cnt_reg == 18'(MS_CYCLES - 1));

   // Port 0 rate code picks blink half period and stretch length
   always_comb
   begin
      case (behav_reg[0][`PLD_BEH_RATE_LSB +: 2])
         2'h0:
         begin
            blink_half  = 8'(`PLD_BLINK_HALF_2P5);
            stretch_len = 9'(`PLD_STRETCH_0_MS);
         end
         2'h1:
         begin
            blink_half  = 8'(`PLD_BLINK_HALF_5);
            stretch_len = 9'(`PLD_STRETCH_1_MS);
         end
         2'h2:
         begin
            blink_half  = 8'(`PLD_BLINK_HALF_10);
            stretch_len = 9'(`PLD_STRETCH_2_MS);
         end
         default:
         begin
            blink_half  = 8'(`PLD_BLINK_HALF_20);
            stretch_len = 9'(`PLD_STRETCH_3_MS);
         end
      endcase
   end

   // Global blink phase, equal high and low halves
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         blink_cnt_reg   <= 8'h00;
         blink_phase_reg <= 1'b0;
      end
      else if (ms_tick)
      begin
         if (blink_cnt_reg >= blink_half - 8'h01)
         begin
            blink_cnt_reg   <= 8'h00;
            blink_phase_reg <= ~blink_phase_reg;
         end
         else
         begin
            blink_cnt_reg <= blink_cnt_reg + 8'h01;
         end
      end
   end

   // 5 kHz pulsing waveform, 20% high
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pulse_cnt_reg <= 16'h0000;
      end
      else if (pulse_cnt_reg == 16'(PULSE_CYCLES - 1))
      begin
         pulse_cnt_reg <= 16'h0000;
      end
      else
      begin
         pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
      end
   end
   assign pulse_on = (pulse_cnt_reg < 16'(PULSE_ON));

   // One-second blink window after reset release
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rb_cnt_reg    <= 10'h000;
         rb_active_reg <= 1'b1;
      end
      else if (rb_active_reg && ms_tick)
      begin
         if (rb_cnt_reg == 10'(`PLD_RESET_BLINK_MS - 1))
         begin
            rb_active_reg <= 1'b0;
         end
         rb_cnt_reg <= rb_cnt_reg + 10'h001;
      end
   end

   // Fast link failure per port
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         fast_link_fail <= '1;
      end
      else
      begin
         for (int p = 0; p < PLD_NP; p++)
         begin
            if (port_stat[p].speed == PLD_SPD_1000 && !port_stat[p].fiber)
            begin
               fast_link_fail[p] <= port_stat[p].gig_integrity_fail;
            end
            else
            begin
               fast_link_fail[p] <= ~port_stat[p].link_up;
            end
         end
      end
   end

   // Mode decode for one LED against its port status
   function automatic pld_eval_t pld_eval(logic [4:0] m, pld_stat_t s, logic fdis,
                                          logic dsel, logic p0, logic pin_a,
                                          logic ser, logic fll);
      pld_eval_t e;
      logic fib;
      logic lnk;
      logic act;
      logic g;
      logic f;
      logic t;
      e   = '0;
      fib = s.fiber & ~fdis;
      lnk = s.link_up & ~(s.fiber & fdis);
      act = (s.tx_act | s.rx_act) & ~(s.fiber & fdis);
      g   = s.speed == PLD_SPD_1000;
      f   = s.speed == PLD_SPD_100;
      t   = s.speed == PLD_SPD_10 && !s.fiber;
      e.has_prim = 1'b1;
      case (m)
         5'd0:  e.prim = lnk;
         5'd1:  e.prim = lnk & g;
         5'd2:  e.prim = lnk & f;
         5'd3:  e.prim = lnk & t;
         5'd4:  e.prim = lnk & (f | g);
         5'd5:  e.prim = lnk & (t | g);
         5'd6:  e.prim = lnk & (t | f);
         5'd7:  e.prim = lnk & fib & (f | g);
         5'd8:  e.prim = lnk & s.full_duplex;
         5'd12: e.prim = s.aneg_fault;
         5'd13: e.prim = p0 & ser;
         5'd14: e.prim = 1'b0;
         5'd15: e.prim = 1'b1;
         5'd16: e.prim = lnk & fib & g;
         5'd17: e.prim = lnk & fib & f;
         5'd21: e.prim = 1'b1;
         5'd22: e.prim = pin_a & fll;
         default: e.prim = 1'b0;
      endcase
      case (m)
         5'd0, 5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7: e.sec = e.prim & act;
         5'd8:  e.sec = lnk & ~s.full_duplex & s.collision;
         5'd9:  e.sec = s.collision;
         5'd10: e.sec = dsel ? s.tx_act : act;
         5'd11: e.sec = fib & (dsel ? s.rx_act : act);
         5'd18: e.sec = fib & g & act;
         5'd19: e.sec = fib & f & act;
         default: e.sec = 1'b0;
      endcase
      if (m == 5'd9 || m == 5'd10 || m == 5'd11 || m == 5'd18 || m == 5'd19)
      begin
         e.has_prim = 1'b0;
      end
      e.no_rblink = (m == 5'd14) || (m == 5'd15);
      e.no_pulse  = (m == 5'd21);
      return e;
   endfunction : pld_eval

   // Per-LED pipeline: decode, blink or stretch, combine, pulse, polarity
   for (genvar i = 0; i < NL; i++)
   begin : g_led
      localparam int P   = i / 2;
      localparam int PIN = i % 2;
      pld_str_state_t str_state_reg;
      logic [8:0]     str_cnt_reg;
      pld_eval_t      ev;
      logic [4:0]     eff_mode;
      logic           ind;
      logic           lit;

      assign eff_mode = {ext_reg[P][`PLD_EXT_EN_LSB + PIN],
                         mode_reg[P][4*PIN +: 4]};
      assign ev = pld_eval(eff_mode, port_stat[P], behav_reg[P][`PLD_BEH_FDIS_BIT],
                           behav_reg[P][`PLD_BEH_DIRSEL_BIT], P == 0, PIN == 0,
                           serial_led_in, fast_link_fail[P]);

      // Pulse-stretch: hold indication on, then off, each for the length
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
         begin
            str_state_reg <= PLD_STR_IDLE;
            str_cnt_reg   <= 9'h000;
         end
         else
         begin
            case (str_state_reg)
               PLD_STR_IDLE:
               begin
                  str_cnt_reg <= 9'h000;
                  if (ev.sec)
                  begin
                     str_state_reg <= PLD_STR_ON;
                  end
               end
               PLD_STR_ON, PLD_STR_OFF:
               begin
                  if (ms_tick)
                  begin
                     str_cnt_reg <= str_cnt_reg + 9'h001;
                  end
                  if (ms_tick && str_cnt_reg >= stretch_len - 9'h001)
                  begin
                     str_cnt_reg <= 9'h000;
                     if (str_state_reg == PLD_STR_ON)
                     begin
                        str_state_reg <= PLD_STR_OFF;
                     end
                     else
                     begin
                        str_state_reg <= ev.sec ? PLD_STR_ON : PLD_STR_IDLE;
                     end
                  end
               end
               default:
               begin
                  str_state_reg <= PLD_STR_IDLE;
               end
            endcase
         end
      end

      // Indication: 50% blink or stretched pulse, chosen per pin
      assign ind = behav_reg[P][`PLD_BEH_STR_LSB + PIN] ?
                   (str_state_reg == PLD_STR_ON) :
                   (ev.sec & blink_phase_reg);

      // Asserted level before pulsing and polarity
      always_comb
      begin
         if (rb_active_reg && ext_reg[P][`PLD_EXT_RBLINK_BIT] && !ev.no_rblink)
         begin
            lit = blink_phase_reg;
         end
         else if (!ev.has_prim)
         begin
            lit = ind;
         end
         else if (behav_reg[P][`PLD_BEH_COMB_LSB + PIN])
         begin
            lit = ev.prim ^ ind;
         end
         else
         begin
            lit = ev.prim;
         end
      end

      assign led_on[i] = lit;

      // Pulsing, then polarity last; polarity bit 0 means active low
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
         begin
            led_pin_reg[i] <= 1'b1;
         end
         else
         begin
            led_pin_reg[i] <= ~(lit & (pulse_on | ~behav_reg[P][`PLD_BEH_PULSE_BIT]
                                      | ev.no_pulse))
                              ^ pol_reg[P][`PLD_POL_LSB + PIN];
         end
      end
   end

   // Pin a and pin b of each port
   always_comb
   begin
      for (int p = 0; p < PLD_NP; p++)
      begin
         led_out_a[p] = led_pin_reg[2*p];
         led_out_b[p] = led_pin_reg[2*p + 1];
      end
   end

endmodule : pld_led_driver

// ### pld_led_properties.sv
// Port assertions for the LED driver.
// Bound into every driver instance.
`timescale 1ns/10ps
module pld_led_properties
   import pld_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst,
   input wire pld_axil_req_t          axil_req,
   input wire pld_axil_rsp_t          axil_rsp,
   input wire pld_stat_t [PLD_NP-1:0] port_stat,
   input wire logic [PLD_NP-1:0]      fast_link_fail
);
   // Copper gigabit port 0 and its inputs
   wire cg = port_stat[0].speed == PLD_SPD_1000 && !port_stat[0].fiber;
   wire lk = port_stat[0].link_up;
   wire gf = port_stat[0].gig_integrity_fail;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_read_late:
      assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid) else $error("r");
   a_read_hold:
      assert property (axil_rsp.rvalid && !axil_req.rready |=>
         axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("rh");
   a_write_late:
      assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
         axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid) else $error("w");
   a_write_hold:
      assert property (axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid) else $error("wh");
   a_write_busy:
      assert property (axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready) else $error("b");
   a_read_busy:
      assert property (axil_rsp.rvalid |-> !axil_rsp.arready) else $error("a");
   a_fail_link:
      assert property (!cg |=> fast_link_fail[0] == !$past(lk)) else $error("fl");
   a_fail_gig:
      assert property (cg |=> fast_link_fail[0] == $past(gf)) else $error("fg");
endmodule : pld_led_properties

bind pld_led_driver pld_led_properties u_props (.core_clk(core_clk), .rst(rst),
   .axil_req(axil_req), .axil_rsp(axil_rsp), .port_stat(port_stat),
   .fast_link_fail(fast_link_fail));

// ### pld_params.svh
// Constants for the per-port LED status driver: register map, field
// positions, reset values and timing figures.
// Assumes a 200 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// Clock rate and time units
`define PLD_CLK_HZ          200000000
`define PLD_MS_PER_S        1000
// Register byte offsets (port n adds n times the port stride)
`define PLD_PORT_STRIDE     8'h10
`define PLD_OFF_MODE        8'h00
`define PLD_OFF_BEHAV       8'h04
`define PLD_OFF_EXT         8'h08
`define PLD_OFF_POL         8'h0C
`define PLD_OFF_STATUS      8'h20
// Mode register: one 4-bit field per LED pin
`define PLD_MODE_A_LSB      0
`define PLD_MODE_B_LSB      4
// Behaviour register fields
`define PLD_BEH_COMB_LSB    0
`define PLD_BEH_STR_LSB     2
`define PLD_BEH_RATE_LSB    4
`define PLD_BEH_PULSE_BIT   6
`define PLD_BEH_FDIS_BIT    7
`define PLD_BEH_DIRSEL_BIT  14
// Extended register fields
`define PLD_EXT_RBLINK_BIT  11
`define PLD_EXT_EN_LSB      12
// Polarity register field, one bit per LED pin
`define PLD_POL_LSB         10
// Reset values
`define PLD_RST_MODE        16'h0000
`define PLD_RST_BEHAV       16'h0003
`define PLD_RST_EXT         16'h0800
`define PLD_RST_POL         16'h0000
// Timing figures
`define PLD_RESET_BLINK_MS  1000
`define PLD_BLINK_HALF_2P5  200
`define PLD_BLINK_HALF_5    100
`define PLD_BLINK_HALF_10   50
`define PLD_BLINK_HALF_20   25
`define PLD_STRETCH_0_MS    50
`define PLD_STRETCH_1_MS    100
`define PLD_STRETCH_2_MS    200
`define PLD_STRETCH_3_MS    400
`define PLD_PULSE_HZ        5000
`define PLD_PULSE_DUTY_PCT  20

`endif

// ### pld_pkg.sv
// Types shared by the LED status driver and its bench.
// Assumes the constants header is compiled alongside.
package pld_pkg;

   localparam int PLD_NP = 2;   // ports served by one block

   typedef enum logic [1:0] {
      PLD_SPD_10   = 2'b00,
      PLD_SPD_100  = 2'b01,
      PLD_SPD_1000 = 2'b10
   } pld_speed_t;

   // Per-port link status from the PHY core
   typedef struct packed {
      logic       link_up;
      pld_speed_t speed;
      logic       fiber;
      logic       full_duplex;
      logic       collision;
      logic       tx_act;
      logic       rx_act;
      logic       aneg_fault;
      logic       gig_integrity_fail;
   } pld_stat_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } pld_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pld_axil_rsp_t;

   // Result of decoding one LED's mode against its port status
   typedef struct packed {
      logic has_prim;
      logic prim;
      logic sec;
      logic no_rblink;
      logic no_pulse;
   } pld_eval_t;

   typedef enum logic [1:0] {
      PLD_STR_IDLE = 2'b00,
      PLD_STR_ON   = 2'b01,
      PLD_STR_OFF  = 2'b10
   } pld_str_state_t;

endpackage : pld_pkg

// ### tb_top.sv
// Self-checking bench for the LED driver with short timing counts.
// Assumes driver, checker and board model compiled first.
`timescale 1ns/10ps
`include "pld_params.svh"
module tb_top
   import pld_pkg::*;
;
   logic            core_clk = 0;
   logic            rst = 1;
   pld_axil_req_t   req = '0;
   pld_axil_rsp_t   rsp;
   pld_stat_t [1:0] st = '0;
   logic [1:0]      la, lb, flf, lit;
   logic [1:0]      pol = 0;
   logic            ser = 0;
   logic [33:0]     q[$];
   logic [31:0]     rs = 79754;
   int              err_total = 0;
   int              check_count = 0;
   int              cyc = 0;
   int              hp[4] = '{`PLD_BLINK_HALF_2P5, `PLD_BLINK_HALF_5, `PLD_BLINK_HALF_10,
                              `PLD_BLINK_HALF_20};
   int              sl[4] = '{`PLD_STRETCH_0_MS, `PLD_STRETCH_1_MS, `PLD_STRETCH_2_MS,
                              `PLD_STRETCH_3_MS};

   pld_led_driver #(.MS_CYCLES(10), .PULSE_CYCLES(10), .PULSE_ON(2)) uut (.core_clk(core_clk),
      .rst(rst), .axil_req(req), .axil_rsp(rsp), .port_stat(st), .serial_led_in(ser),
      .led_out_a(la), .led_out_b(lb), .fast_link_fail(flf));
   pld_led_board board (.pin_a(la), .pol_a(pol), .lit_a(lit));

   // Clock, 5 ns period
   always #2.5 core_clk = ~core_clk;

   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   // Lit state of pin a for a mode with no traffic
   function automatic logic lit_of(int m, pld_stat_t s);
      logic k, g, h, t;
      k = s.link_up;
      g = s.speed == PLD_SPD_1000;
      h = s.speed == PLD_SPD_100;
      t = s.speed == PLD_SPD_10;
      case (m)
         0: return k;
         1: return k && g;
         2: return k && h;
         3: return k && t && !s.fiber;
         4: return k && !t;
         5: return k && !h;
         6: return k && !g;
         7: return k && s.fiber && !t;
         8: return k && s.full_duplex;
         12: return s.aneg_fault;
         13: return ser;
         15, 21: return 1'b1;
         16: return k && s.fiber && g;
         17: return k && s.fiber && h;
         22: return (g && !s.fiber) ? s.gig_integrity_fail : !k;
         default: return 1'b0;
      endcase
   endfunction : lit_of

   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge core_clk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do
      begin
         @(negedge core_clk);
         aw = rsp.awready;
         w  = rsp.wready;
         b  = rsp.bvalid;
         if (b)
            chk(rsp.bresp, 2'b00, "bresp");
         @(posedge core_clk);
         if (aw)
            req.awvalid <= 1'b0;
         if (w)
            req.wvalid <= 1'b0;
      end while (!b);
      req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic g, v;
      @(posedge core_clk);
      q.push_back(e);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do
      begin
         @(negedge core_clk);
         g = rsp.arready;
         v = rsp.rvalid;
         @(posedge core_clk);
         if (g)
            req.arvalid <= 1'b0;
      end while (!v);
      req.rready <= 1'b0;
   endtask : rd

   // Cycles until port 1 pin a (or pin b) changes
   task automatic tog(input bit b, output int k);
      logic v;
      v = b ? lb[1] : la[1];
      k = 0;
      do
      begin
         @(negedge core_clk);
         k++;
      end while ((b ? lb[1] : la[1]) === v);
   endtask : tog

   // Compares each read answer with the oldest note
   always @(negedge core_clk)
      if (rsp.rvalid && req.rready)
         chk({rsp.rresp, rsp.rdata}, q.pop_front(), "read");

   // Cuts a hung run short
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_total++;
         end_of_test;
      end
   end

   // Main sequence
   initial
   begin
      int m, n;
      logic [31:0] r;
      pld_stat_t s;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (1000) @(negedge core_clk);
      chk(la, 2'b11, "blink off");
      repeat (2000) @(negedge core_clk);
      chk(la, 2'b00, "blink on");
      repeat (7600) @(negedge core_clk);
      chk(la, 2'b11, "blink end");
      rd(8'h08, 34'h800);
      rd(8'h0C, 34'h0);
      rd(8'h24, {2'b10, 32'h0});
      wr(8'h04, 32'h0);
      for (n = 0; n < 40; n++)
      begin
         r = rnd();
         m = r[31:16] % 24;
         s = pld_stat_t'(r[9:0] & 10'h3E3);
         s.speed = pld_speed_t'(r[15:14] % 2'd3);
         if (s.speed == PLD_SPD_10)
            s.fiber = 1'b0;
         wr(8'h00, 32'(m % 16));
         wr(8'h08, {19'h0, m > 15, 12'h800});
         wr(8'h0C, {21'h0, r[20], 10'h0});
         st <= {s, s};
         ser <= r[21];
         pol <= {1'b0, r[20]};
         repeat (3) @(negedge core_clk);
         chk(lit[0], lit_of(m, s), "mode");
         rd(8'h20, {30'h0, {3{s.link_up}}, lit_of(m, s)});
      end
      wr(8'h08, 32'h800);
      wr(8'h00, 32'hF);
      wr(8'h04, 32'h40);
      for (n = 0; n < 2; n++)
      begin
         m = 0;
         repeat (100)
         begin
            @(negedge core_clk);
            m += lit[0];
         end
         chk(m, n ? 100 : 20, "pulse");
         wr(8'h08, 32'h1800);
         wr(8'h00, 32'h5);
      end
      st <= {2{pld_stat_t'(10'h204)}};
      for (n = 0; n < 4; n++)
      begin
         wr(8'h04, 32'(n * 16));
         wr(8'h14, 32'((3 - n) * 16 + 11));
         repeat (3) tog(1'b0, m);
         chk(m, hp[n] * 10, "rate");
         repeat (3) tog(1'b1, m);
         chk(m, sl[n] * 10, "stretch");
      end
      end_of_test;
   end
endmodule : tb_top
